// ---- hw/i2cbr_top.sv ----
`timescale 1ns/100ps
module i2cbr_top
    import i2cbr_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR    = 7'h2A,
    parameter int         SLOT_CYCLES = SLOT_CYC
) (
    input  wire logic       core_clk,        // Core clock, 50 MHz.
    input  wire logic       sys_rst,         // Async reset, high.
    input  wire logic       scl_i,           // SCL pin level.
    output logic            scl_o,           // SCL drive value.
    output logic            scl_oe_n,        // SCL drive enable, low.
    input  wire logic       sda_i,           // SDA pin level.
    output logic            sda_o,           // SDA drive value.
    output logic            sda_oe_n,        // SDA drive enable, low.
    input  wire logic       engine_busy,     // Hash, EEPROM or sleep.
    output logic            line_start,      // Block receive launch.
    output logic [5:0]      line_byte_total, // Bytes to receive.
    output logic            line_busy_flag,  // Line activity running.
    input  wire logic [7:0] rx_data,         // Byte from the line.
    input  wire logic       rx_valid,        // Line byte present.
    output logic            rx_ready         // Buffer has room.
);
    localparam int         ACT_LIM   = ACT_MAX_CYC;
    localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES - 1);

    // ========================================
    // Elaboration check on the slot timebase.
    if (SLOT_CYCLES < 2 || SLOT_CYCLES > 65536) begin : g_bad
        $error("i2cbr_top: SLOT_CYCLES out of range 2..65536");
    end

    // ========================================
    // Pin synchronisers; the second and third stages are read.
    logic scl_m_reg, scl_s_reg, scl_d_reg;
    logic sda_m_reg, sda_s_reg, sda_d_reg;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'b111;
            {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'b111;
        end else begin
            {scl_m_reg, scl_s_reg, scl_d_reg} <= {scl_i, scl_m_reg, scl_s_reg};
            {sda_m_reg, sda_s_reg, sda_d_reg} <= {sda_i, sda_m_reg, sda_s_reg};
        end
    end

    // Bus events seen in the core clock domain.
    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise  = scl_s_reg && !scl_d_reg;
    assign scl_fall  = !scl_s_reg && scl_d_reg;
    assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
    assign stop_det  = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;

    // ========================================
    // Slave port state.
    i2cbr_state_e st_reg;
    logic [3:0]   bit_cnt_reg;
    logic [7:0]   shift_reg;
    logic [1:0]   idx_reg;
    logic         rw_reg;
    logic [7:0]   ptr_reg;
    logic         ack_reg;
    logic         mack_reg;
    logic         cmd_arm_reg;
    logic         go_arm_reg;
    logic [5:0]   bs_reg;
    logic [7:0]   tx_reg;
    logic         busy_reg;
    logic [7:0]   sp_mem [SP_BYTES];

    // ========================================
    // Byte decode at the falling edge that closes the eighth bit.
    logic       byte_done, is_addr, is_ptr, is_data, in_cmd, sp_hit;
    logic       addr_ok, code_busy, code_ok, param_byte, data_ack;
    logic       byte_ack, sp_i2c_we, launch, tx_load;
    logic [5:0] bs_bytes;
    logic [7:0] tx_sel, ptr_inc;

    assign byte_done  = (st_reg == ST_RX) && scl_fall &&
                        (bit_cnt_reg == 4'(BITS_BYTE));
    assign is_addr    = idx_reg == 2'd0;
    assign is_ptr     = idx_reg == 2'd1;
    assign is_data    = idx_reg == 2'd2;
    assign in_cmd     = ptr_reg == REG_CMD;
    assign sp_hit     = ptr_reg <= SP_LAST;
    assign addr_ok    = (shift_reg[7:1] == OWN_ADDR) &&
                        !engine_busy;
    assign code_ok    = is_data && in_cmd && !cmd_arm_reg &&
                        (shift_reg == CMD_BLOCK_RX);
    assign code_busy  = code_ok && busy_reg;
    assign param_byte = is_data && in_cmd && cmd_arm_reg;
    // Unknown command codes are refused like a busy line.
    assign data_ack   = in_cmd ? ((code_ok && !busy_reg) || param_byte)
                               : (ptr_reg != REG_STATUS);
    assign byte_ack   = is_addr ? addr_ok : (is_ptr || data_ack);
    assign sp_i2c_we  = byte_done && is_data && sp_hit;
    assign launch     = (st_reg == ST_RACK) && scl_rise && go_arm_reg;
    assign bs_bytes   = (bs_reg == 6'd0) ? 6'd1 : bs_reg;
    // Status reads do not advance; the host polls them in a loop.
    assign ptr_inc    = (ptr_reg == REG_STATUS) ? ptr_reg : ptr_reg + 8'd1;
    assign tx_sel     = sp_hit ? sp_mem[ptr_reg[6:0]] :
                        (ptr_reg == REG_STATUS) ?
                        8'(busy_reg) << STAT_BUSY : READ_FILL;
    assign tx_load    = scl_fall && ((st_reg == ST_RACK && rw_reg) ||
                                     (st_reg == ST_TACK && mack_reg));

    // ========================================
    // Sequencer. START or repeated START always restarts at the
    // address byte; STOP parks the port and releases SDA.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg      <= ST_IDLE;
            bit_cnt_reg <= 4'd0;
            shift_reg   <= 8'h00;
            idx_reg     <= 2'd0;
            rw_reg      <= 1'b0;
            ptr_reg     <= PTR_RST;
            ack_reg     <= 1'b0;
            mack_reg    <= 1'b0;
            cmd_arm_reg <= 1'b0;
            go_arm_reg  <= 1'b0;
            bs_reg      <= 6'd0;
            tx_reg      <= 8'h00;
            sda_oe_n    <= 1'b1;
        end else if (start_det) begin
            st_reg      <= ST_RX;
            bit_cnt_reg <= 4'd0;
            idx_reg     <= 2'd0;
            cmd_arm_reg <= 1'b0;
            go_arm_reg  <= 1'b0;
            sda_oe_n    <= 1'b1;
        end else if (stop_det) begin
            st_reg      <= ST_IDLE;
            cmd_arm_reg <= 1'b0;
            go_arm_reg  <= 1'b0;
            sda_oe_n    <= 1'b1;
        end else begin
            case (st_reg)
                ST_RX: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                    end
                    if (byte_done) begin
                        st_reg   <= byte_ack ? ST_RACK : ST_IDLE;
                        ack_reg  <= byte_ack;
                        sda_oe_n <= !byte_ack;
                        idx_reg  <= is_data ? idx_reg : idx_reg + 2'd1;
                        if (is_addr) begin
                            rw_reg <= shift_reg[0];
                        end else if (is_ptr) begin
                            ptr_reg <= shift_reg;
                        end else if (param_byte) begin
                            bs_reg      <= shift_reg[BS_MSB:BS_LSB];
                            go_arm_reg  <= 1'b1;
                            cmd_arm_reg <= 1'b0;
                            ptr_reg     <= REG_STATUS;
                        end else if (code_ok) begin
                            cmd_arm_reg <= !busy_reg;
                        end else if (!in_cmd && data_ack) begin
                            ptr_reg <= ptr_inc;
                        end
                    end
                end
                ST_RACK: begin
                    if (launch) begin
                        go_arm_reg <= 1'b0;
                    end
                    if (scl_fall) begin
                        ack_reg     <= 1'b0;
                        bit_cnt_reg <= 4'd0;
                        st_reg      <= rw_reg ? ST_TX : ST_RX;
                        sda_oe_n    <= rw_reg ? tx_sel[7] : 1'b1;
                        tx_reg      <= tx_sel;
                        ptr_reg     <= rw_reg ? ptr_inc : ptr_reg;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                        tx_reg      <= {tx_reg[6:0], 1'b0};
                        if (bit_cnt_reg == 4'(BITS_BYTE - 1)) begin
                            st_reg   <= ST_TACK;
                            sda_oe_n <= 1'b1;
                        end else begin
                            sda_oe_n <= tx_reg[6];
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise) begin
                        mack_reg <= !sda_s_reg;
                    end
                    if (tx_load) begin
                        st_reg      <= ST_TX;
                        bit_cnt_reg <= 4'd0;
                        tx_reg      <= tx_sel;
                        sda_oe_n    <= tx_sel[7];
                        ptr_reg     <= ptr_inc;
                    end else if (scl_fall) begin
                        st_reg   <= ST_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                end
                ST_IDLE: begin
                    sda_oe_n <= 1'b1;
                end
                default: begin
                    st_reg   <= ST_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Both pins are open drain; the device never stretches SCL.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_o    <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_o    <= 1'b0;
        end else begin
            scl_o    <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_o    <= 1'b0;
        end
    end

    // ========================================
    // Bit-slot timebase; launch is on the ack rise, well inside the
    // activity deadline even with the synchroniser delay.
    logic [15:0] slot_cnt_reg;
    logic [8:0]  slots_left_reg;
    logic        slot_end;
    assign slot_end = slot_cnt_reg == SLOT_LAST;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_reg       <= 1'b0;
            slot_cnt_reg   <= 16'd0;
            slots_left_reg <= 9'd0;
        end else if (launch) begin
            busy_reg       <= 1'b1;
            slot_cnt_reg   <= 16'd0;
            slots_left_reg <= {bs_bytes, 3'b000};
        end else if (busy_reg) begin
            slot_cnt_reg <= slot_end ? 16'd0 : slot_cnt_reg + 16'd1;
            if (slot_end) begin
                slots_left_reg <= slots_left_reg - 9'd1;
                busy_reg       <= slots_left_reg != 9'd1;
            end
        end
    end

    // Launch strobe and byte count towards the line engine.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_start      <= 1'b0;
            line_byte_total <= 6'd0;
        end else begin
            line_start      <= launch;
            line_byte_total <= launch ? bs_bytes : line_byte_total;
        end
    end
    assign line_busy_flag = busy_reg;

    // ========================================
    // Line bytes pass a FIFO; the host's own scratchpad writes take
    // the single write port, so the drain stalls in those cycles.
    logic [7:0] fifo_data;
    logic       fifo_valid, fifo_ready, fifo_take;
    logic [5:0] sp_wr_idx_reg;

    i2cbr_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_data   (rx_data),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    assign fifo_ready = !sp_i2c_we;
    assign fifo_take  = fifo_valid && fifo_ready &&
                        (sp_wr_idx_reg < line_byte_total);

    // Scratchpad storage; surplus line bytes are dropped.
    always_ff @(posedge core_clk) begin
        if (sp_i2c_we) begin
            sp_mem[ptr_reg[6:0]] <= shift_reg;
        end else if (fifo_take) begin
            sp_mem[7'(sp_wr_idx_reg)] <= fifo_data;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_wr_idx_reg <= 6'd0;
        end else if (launch) begin
            sp_wr_idx_reg <= 6'd0;
        end else if (fifo_take) begin
            sp_wr_idx_reg <= sp_wr_idx_reg + 6'd1;
        end
    end

    // ========================================
    // Checks. Busy length is measured by a helper counter.
    logic [19:0] busy_len_reg, exp_len_reg;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_len_reg <= 20'd0;
            exp_len_reg  <= 20'd0;
        end else if (launch) begin
            busy_len_reg <= 20'd0;
            exp_len_reg  <= 20'({bs_bytes, 3'b000}) * 20'(SLOT_CYCLES);
        end else if (busy_reg) begin
            busy_len_reg <= busy_len_reg + 20'd1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_busy_length: assert property (
        $fell(busy_reg) |-> busy_len_reg == exp_len_reg
    ) else $error("busy flag length differs from count times slots");

    a_launch_deadline: assert property (
        (st_reg == ST_RACK && go_arm_reg && scl_s_reg) |->
            ##[0:ACT_LIM] busy_reg
    ) else $error("line activity late after parameter ack");

    a_busy_refuse: assert property (
        (byte_done && code_busy) |=> sda_oe_n && st_reg == ST_IDLE
    ) else $error("command acknowledged while line busy");

    a_status_ptr: assert property (
        launch |-> ptr_reg == REG_STATUS
    ) else $error("read pointer not at status after command");

    a_addr_nack: assert property (
        (byte_done && is_addr && engine_busy) |=> sda_oe_n
    ) else $error("address acknowledged while engine busy");

    a_addr_ack: assert property (
        (byte_done && is_addr && addr_ok) |=> !sda_oe_n [*2]
    ) else $error("own address not acknowledged");

    a_ack_hold: assert property (
        (st_reg == ST_RACK && ack_reg && scl_s_reg) |-> !sda_oe_n
    ) else $error("SDA released during ack high phase");

    a_sda_change_low: assert property (
        ($changed(sda_oe_n) && !$past(start_det) && !$past(stop_det))
            |-> !$past(scl_s_reg)
    ) else $error("SDA drive changed while SCL high");

    a_sp_start: assert property (
        launch |=> sp_wr_idx_reg == 6'd0 && busy_reg
    ) else $error("scratchpad fill does not start at zero");

    a_stop_idle: assert property (
        (stop_det && !start_det) |=> st_reg == ST_IDLE && sda_oe_n
    ) else $error("STOP did not end the transfer");

endmodule

// ---- common/i2cbr_pkg.sv ----
// Functional notes
// - Command E1h starts block receive.
// - Store 1 to 63 bytes from 00h.
// - Bits 5:0 give count, zero means one.
// - Command while line busy: no ack, dropped.
// - Line activity starts within 1.09 us.
// - Accepted command points reads at status.
// - Standard and fast mode rates supported.
// - Bytes MSB first, ack bit follows.
// - Address LSB selects write or read.
// - Repeated START begins a new transfer.
// - SDA changes only while SCL low.
// - Receiver samples SDA on SCL rise.
// - Device shifts data after SCL fall.
// - Ack holds SDA low whole high phase.
// - Engine busy or asleep: address not acked.
// - Ready device acks its own address.
// - Commands go to 60h, no increment.
package i2cbr_pkg;

    // ========================================
    // Register map seen through the slave port.
    localparam logic [7:0] REG_CMD      = 8'h60;
    localparam logic [7:0] REG_STATUS   = 8'h61;
    localparam logic [7:0] SP_LAST      = 8'h4B;
    localparam int         SP_BYTES     = 76;
    localparam logic [7:0] PTR_RST      = 8'h00;
    localparam logic [7:0] READ_FILL    = 8'hFF;

    // ========================================
    // Command codes and parameter fields.
    localparam logic [7:0] CMD_BLOCK_RX = 8'hE1;
    localparam int         BS_MSB       = 5;
    localparam int         BS_LSB       = 0;
    localparam int         STAT_BUSY    = 0;
    localparam int         BITS_BYTE    = 8;

    // ========================================
    // Timing, converted to core clock cycles.
    localparam int  CLK_PERIOD_PS = 20000;
    localparam real T_ACT_MAX_US  = 1.09;
    localparam int  ACT_MAX_CYC   =
        int'(T_ACT_MAX_US * 1.0e6) / CLK_PERIOD_PS;
    localparam real T_SLOT_US     = 10.0;
    localparam int  SLOT_CYC      =
        int'(T_SLOT_US * 1.0e6) / CLK_PERIOD_PS;
    localparam int  FIFO_DEPTH    = 16;

    // ========================================
    // Slave port sequencer states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX   = 5'b00010,
        ST_RACK = 5'b00100,
        ST_TX   = 5'b01000,
        ST_TACK = 5'b10000
    } i2cbr_state_e;

endpackage

// ---- hw/i2cbr_fifo.sv ----
`timescale 1ns/100ps
module i2cbr_fifo
    import i2cbr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             core_clk,  // Core clock.
    input  wire logic             sys_rst,   // Async reset, high.
    input  wire logic [WIDTH-1:0] in_data,   // Write data.
    input  wire logic             in_valid,  // Write request.
    output logic                  in_ready,  // Room for a word.
    output logic      [WIDTH-1:0] out_data,  // Head word.
    output logic                  out_valid, // Head word present.
    input  wire logic             out_ready  // Drain accepts head.
);
    localparam int AW = $clog2(DEPTH);

    // ========================================
    // Elaboration check: pointers wrap, so depth is a power of two.
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("i2cbr_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    // ========================================
    // Handshakes; flags are registered so in_ready and out_valid come from flops.
    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem[rd_ptr_reg];

    // Storage has no reset; only the pointers, count and flags are reset.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and full/empty flags.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
            in_ready   <= 1'b0;
            out_valid  <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            cnt_reg    <= cnt_next;
            in_ready   <= cnt_next != (AW+1)'(DEPTH);
            out_valid  <= cnt_next != '0;
        end
    end

endmodule

// ---- test/i2cbr_host.sv ----
`timescale 1ns/100ps
// ==========================================================
// Host bus master; SCL rests high and still between frames.
module i2cbr_host (
    output logic      scl,     // Clock line, host only.
    output logic      sda_drv, // Data drive, 0 pulls low.
    input  wire logic sda_in   // Resolved data line.
);
    // Both lines stay released until a frame begins.
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // The odd first delay keeps frames out of phase with the core clock;
    // SCL rises only once a device acknowledge has surely been released.
    task automatic start();
        #13 sda_drv = 1'b1;
        #80 scl = 1'b1;
        #80 sda_drv = 1'b0;
        #80 scl = 1'b0;
    endtask

    // Data rises under a high clock, then the bus idles a while.
    task automatic stop();
        #40 sda_drv = 1'b0;
        #80 scl = 1'b1;
        #80 sda_drv = 1'b1;
        #160;
    endtask

    // One pulse; data moves only while the clock is low.
    task automatic bit_x(input logic b, output logic r);
        #40 sda_drv = b;
        #80 scl = 1'b1;
        r = sda_in;
        #40 scl = 1'b0;
    endtask

    // Byte out, MSB first, then the acknowledge slot is sampled.
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    // Byte in; a low acknowledge asks for more, a high one ends the read.
    task automatic rbyte(input logic more,
                         output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~more, r);
    endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module testbench;
    localparam int SLOTS = 80;
    logic       core_clk, sys_rst, engine_busy, rx_valid, rx_ready;
    logic [7:0] rx_data;
    logic       scl_o, scl_oe_n, sda_o, sda_oe_n, line_start;
    logic       line_busy_flag, scl_w, host_sda;
    logic [5:0] line_byte_total;
    wire        sda_w;
    int         n_fail = 0, tests_run = 0, n_start = 0, busy_cyc = 0;

    // ==========================================================
    // Open drain data line: any party pulling low beats the pull-up.
    assign sda_w = host_sda & (sda_oe_n | sda_o);

    i2cbr_top #(.OWN_ADDR(7'h2A), .SLOT_CYCLES(SLOTS)) i2cbr_top_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .engine_busy(engine_busy),
        .line_start(line_start), .line_byte_total(line_byte_total),
        .line_busy_flag(line_busy_flag), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready));
    i2cbr_host i2cbr_host_inst (.scl(scl_w), .sda_drv(host_sda),
        .sda_in(sda_w));

    // Clock; launches and busy cycles are counted apart from the tasks.
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (line_start === 1'b1)
            n_start <= n_start + 1;
        if (line_busy_flag === 1'b1)
            busy_cyc <= busy_cyc + 1;
    end

    // Write one byte and compare the acknowledge with the expected one.
    task automatic wr(input logic [7:0] d, input logic exp);
        logic a;
        i2cbr_host_inst.wbyte(d, a);
        `CHK(a, exp)
    endtask

    // Offer one line byte and hold it until the buffer has room.
    task automatic feed(input logic [7:0] d);
        @(posedge core_clk);
        rx_data  <= d;
        rx_valid <= 1'b1;
        @(negedge core_clk);
        repeat (50) if (rx_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        rx_valid <= 1'b0;
    endtask

    // Foreign address, occupied engine, then own address.
    task automatic t_addr();
        i2cbr_host_inst.start();
        wr(8'h56, 1'b0);
        i2cbr_host_inst.stop();
        @(posedge core_clk);
        engine_busy <= 1'b1;
        i2cbr_host_inst.start();
        wr(8'h54, 1'b0);
        i2cbr_host_inst.stop();
        @(posedge core_clk);
        engine_busy <= 1'b0;
        i2cbr_host_inst.start();
        wr(8'h54, 1'b1);
        i2cbr_host_inst.stop();
        `CHK({scl_oe_n, scl_o, sda_o}, 3'b100)
    endtask

    // Host write at the last scratchpad location, one lost byte past it,
    // then a read back across the end of the scratchpad.
    task automatic t_pad();
        logic [7:0] d;
        i2cbr_host_inst.start();
        wr(8'h54, 1'b1);
        wr(8'h4B, 1'b1);
        wr(8'h3C, 1'b1);
        wr(8'h77, 1'b1);
        i2cbr_host_inst.start();
        wr(8'h54, 1'b1);
        wr(8'h4B, 1'b1);
        i2cbr_host_inst.start();
        wr(8'h55, 1'b1);
        i2cbr_host_inst.rbyte(1'b1, d);
        `CHK(d, 8'h3C)
        i2cbr_host_inst.rbyte(1'b0, d);
        `CHK(d, 8'hFF)
        i2cbr_host_inst.stop();
    endtask

    // Block receive; one spare byte is offered to prove the count holds.
    task automatic t_cmd(input logic [7:0] prm, input int cnt,
                         input logic [7:0] first, input logic [7:0] keep1);
        int         s0, b0;
        logic [7:0] d;
        s0 = n_start;
        b0 = busy_cyc;
        i2cbr_host_inst.start();
        wr(8'h54, 1'b1);
        wr(8'h60, 1'b1);
        wr(8'hE1, 1'b1);
        wr(prm, 1'b1);
        i2cbr_host_inst.stop();
        #680;
        `CHK(n_start - s0, 1)
        `CHK(line_byte_total, 6'(cnt))
        i2cbr_host_inst.start();
        wr(8'h55, 1'b1);
        i2cbr_host_inst.rbyte(1'b0, d);
        `CHK(d, 8'h01)
        i2cbr_host_inst.start();
        wr(8'h54, 1'b1);
        wr(8'h60, 1'b1);
        wr(8'hE1, 1'b0);
        i2cbr_host_inst.stop();
        for (int i = 0; i <= cnt; i++)
            feed(first + 8'(i));
        repeat (6000) if (line_busy_flag === 1'b1) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(busy_cyc - b0, cnt * 8 * SLOTS)
        `CHK(n_start - s0, 1)
        i2cbr_host_inst.start();
        wr(8'h54, 1'b1);
        wr(8'h00, 1'b1);
        i2cbr_host_inst.start();
        wr(8'h55, 1'b1);
        i2cbr_host_inst.rbyte(1'b1, d);
        `CHK(d, first)
        i2cbr_host_inst.rbyte(1'b0, d);
        `CHK(d, keep1)
        i2cbr_host_inst.stop();
    endtask

    // Reset for ten cycles, let the idle bus settle, then the scenarios.
    initial begin
        sys_rst     = 1'b1;
        engine_busy = 1'b0;
        rx_valid    = 1'b0;
        rx_data     = 8'h00;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        t_addr();
        t_pad();
        t_cmd(8'hC2, 2, 8'hA0, 8'hA1);
        t_cmd(8'h40, 1, 8'h50, 8'hA1);
        tally_and_finish();
    end

    // The whole run needs about 90 us; a hang is cut at 1 ms.
    initial begin
        #1000000;
        n_fail++;
        tally_and_finish();
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
endmodule
